// ### heater_current_alarm_monitor.sv
/*
  heater current alarm monitor: apb registers, period timing, two
  current-sense channels, alarm 1 output, lamp, display flash and interrupt.
  assumes current_sense_input samples are tenths of an ampere, synchronous
  to clk_in, and heat_on_in is the heating output state.
*/
// Decided for this implementation: the register addresses and register access over APB.
`timescale 1ns/100ps
// Notes on behaviour
// RL1: monitor current per channel, 0.0 to 55.0 A
// RL2: above 55.0 A monitor reads FFFF
// RL3: on periods of 100 ms or less ignored
// RL4: off periods of 100 ms or less ignored
// RL5: break alarm when on current below threshold
// RL6: break threshold 0..50, default 0, ends force
// RL7: overcurrent alarm when on current above threshold
// RL8: overcurrent threshold 0..50, default 50, ends force
// RL9: leakage sampled only while output off
// RL10: short alarm when leakage above threshold
// RL11: short threshold 0..50, default 50, ends force
// RL12: break/overcurrent lights lamp, flashes heater monitor
// RL13: short alarm lights lamp, flashes leakage monitor
// RL14: channel 2 only with two sense inputs
// RL15: monitor needs break/overcurrent use; alarm 1 output; here the heater monitor latches every qualified on period regardless of use
// RL16: short functions only when short use enabled
// RL17: tenth-ampere compare after each qualifying period
module heater_current_alarm_monitor #(
  parameter bit TWO_CHANNELS = 1'b1
) (
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // apb slave
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [7:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  // heating output and current sense
  input wire logic heat_on_in,
  input wire logic [heater_alarm_pkg::AMP_W-1:0] current_sense_input1_in,
  input wire logic [heater_alarm_pkg::AMP_W-1:0] current_sense_input2_in,
  // alarm indications
  output logic alarm1_out,
  output logic heater_alarm_lamp_out,
  output logic [3:0] flash_out,
  output logic irq_out
);
  import heater_alarm_pkg::*;

  typedef struct packed {
    logic [3:0] ctrl;
    logic [AMP_W-1:0] break1;
    logic [AMP_W-1:0] overcur1;
    logic [AMP_W-1:0] short1;
    logic [AMP_W-1:0] break2;
    logic [AMP_W-1:0] overcur2;
    logic [AMP_W-1:0] short2;
    logic [ALM_W-1:0] status;
    logic [ALM_W-1:0] mask;
    logic [ALM_W-1:0] alarm_prev;
    logic [31:0] rdata;
    logic ready;
    logic err;
    logic alarm1;
    logic lamp;
    logic [3:0] flash;
    logic irq;
  } top_state_t;

  top_state_t state;
  top_state_t next_state;
  logic on_done;
  logic off_done;
  logic [ALM_W-1:0] alarms;
  logic [ALM_W-1:0] rises;
  logic access;
  logic [AMP_W-1:0] wr_amps;

  channel_if ch1 ();
  channel_if ch2 ();

  // clamp a written threshold to the settable range
  function automatic logic [AMP_W-1:0] clamp(input logic [31:0] d);
    clamp = (d > 32'(AMP_MAX_SETTING)) ? AMP_MAX_SETTING : d[AMP_W-1:0];
  endfunction : clamp

  function automatic logic [31:0] amps_word(input logic [AMP_W-1:0] a);
    amps_word = {22'h000000, a};
  endfunction : amps_word

  // =====================================================
  // period timing and channels
  period_timer timer (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .heat_on_in(heat_on_in),
    .on_done_out(on_done),
    .off_done_out(off_done)
  );

  assign ch1.sample = current_sense_input1_in;
  assign ch1.on_done = on_done;
  assign ch1.off_done = off_done;
  assign ch1.break_th = state.break1;
  assign ch1.overcur_th = state.overcur1;
  assign ch1.short_th = state.short1;
  assign ch1.break_use = state.ctrl[CTRL_BREAK_USE];
  assign ch1.overcur_use = state.ctrl[CTRL_OVERCUR_USE];
  assign ch1.short_use = state.ctrl[CTRL_SHORT_USE];

  // RL14 channel 2 fitted
  assign ch2.sample = TWO_CHANNELS ? current_sense_input2_in : AMP_ZERO;
  assign ch2.on_done = on_done && TWO_CHANNELS;
  assign ch2.off_done = off_done && TWO_CHANNELS;
  assign ch2.break_th = state.break2;
  assign ch2.overcur_th = state.overcur2;
  assign ch2.short_th = state.short2;
  assign ch2.break_use = state.ctrl[CTRL_BREAK_USE] && TWO_CHANNELS;
  assign ch2.overcur_use = state.ctrl[CTRL_OVERCUR_USE] && TWO_CHANNELS;
  assign ch2.short_use = state.ctrl[CTRL_SHORT_USE] && TWO_CHANNELS;

  channel_eval chan1 (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .ch(ch1)
  );

  channel_eval chan2 (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .ch(ch2)
  );

  assign alarms = {ch2.alarm, ch1.alarm};
  assign rises = alarms & ~state.alarm_prev;
  assign access = psel_in && penable_in && !state.ready;
  assign wr_amps = clamp(pwdata_in);

  // =====================================================
  // registers, bus and alarm outputs
  always_comb begin
    next_state = state;
    next_state.ready = access;
    next_state.err = 1'b0;
    next_state.rdata = 32'h00000000;
    next_state.alarm_prev = alarms;
    if (access && pwrite_in) begin
      unique case (paddr_in)
        REG_CTRL: next_state.ctrl = pwdata_in[3:0];
        // RL6 break threshold range
        REG_BREAK1: next_state.break1 = wr_amps;
        // RL8 overcurrent threshold range
        REG_OVERCUR1: next_state.overcur1 = wr_amps;
        // RL11 short threshold range
        REG_SHORT1: next_state.short1 = wr_amps;
        REG_BREAK2: next_state.break2 = wr_amps;
        REG_OVERCUR2: next_state.overcur2 = wr_amps;
        REG_SHORT2: next_state.short2 = wr_amps;
        REG_STATUS: next_state.status = state.status & ~pwdata_in[ALM_W-1:0];
        REG_MASK: next_state.mask = pwdata_in[ALM_W-1:0];
        REG_MON_HEAT1, REG_MON_LEAK1, REG_MON_HEAT2, REG_MON_LEAK2, REG_ALARM: begin
          next_state.err = 1'b0;
        end
        default: next_state.err = 1'b1;
      endcase
    end else if (access) begin
      unique case (paddr_in)
        REG_CTRL: next_state.rdata = {28'h0000000, state.ctrl};
        REG_BREAK1: next_state.rdata = amps_word(state.break1);
        REG_OVERCUR1: next_state.rdata = amps_word(state.overcur1);
        REG_SHORT1: next_state.rdata = amps_word(state.short1);
        REG_BREAK2: next_state.rdata = amps_word(state.break2);
        REG_OVERCUR2: next_state.rdata = amps_word(state.overcur2);
        REG_SHORT2: next_state.rdata = amps_word(state.short2);
        REG_MON_HEAT1: next_state.rdata = {16'h0000, ch1.mon_heat};
        REG_MON_LEAK1: next_state.rdata = {16'h0000, ch1.mon_leak};
        REG_MON_HEAT2: next_state.rdata = {16'h0000, ch2.mon_heat};
        REG_MON_LEAK2: next_state.rdata = {16'h0000, ch2.mon_leak};
        REG_STATUS: next_state.rdata = {26'h0000000, state.status};
        REG_MASK: next_state.rdata = {26'h0000000, state.mask};
        REG_ALARM: next_state.rdata = {26'h0000000, alarms};
        default: next_state.err = 1'b1;
      endcase
    end
    // new alarms win over a clear in the same cycle
    next_state.status = next_state.status | rises;
    next_state.irq = |(next_state.status & next_state.mask);
    // RL15 routed to alarm 1
    next_state.alarm1 = (|alarms) && state.ctrl[CTRL_ALARM1_ASSIGNED];
    // RL12 RL13 lamp on alarm
    next_state.lamp = |alarms;
    // RL12 heater monitor flash
    next_state.flash[0] = alarms[ALM_BREAK1] || alarms[ALM_OVERCUR1];
    // RL13 leakage monitor flash
    next_state.flash[1] = alarms[ALM_SHORT1];
    next_state.flash[2] = alarms[ALM_BREAK2] || alarms[ALM_OVERCUR2];
    next_state.flash[3] = alarms[ALM_SHORT2];
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      state <= '0;
      state.ctrl <= CTRL_RESET;
      state.break1 <= BREAK_DEFAULT;
      state.overcur1 <= OVERCUR_DEFAULT;
      state.short1 <= SHORT_DEFAULT;
      state.break2 <= BREAK_DEFAULT;
      state.overcur2 <= OVERCUR_DEFAULT;
      state.short2 <= SHORT_DEFAULT;
    end else begin
      state <= next_state;
    end
  end

  assign prdata_out = state.rdata;
  assign pready_out = state.ready;
  assign pslverr_out = state.err;
  assign alarm1_out = state.alarm1;
  assign heater_alarm_lamp_out = state.lamp;
  assign flash_out = state.flash;
  assign irq_out = state.irq;
endmodule : heater_current_alarm_monitor

// ### heater_alarm_pkg.sv
/*
  constants, register map and types for the heater current alarm monitor.
  assumes a 100 MHz clock and currents coded as unsigned tenths of an ampere.
*/
package heater_alarm_pkg;
  // =====================================================
  // timing
  localparam int CLK_MHZ = 100;
  localparam int MIN_PERIOD_MS = 100;
  localparam int MIN_PERIOD_CYCLES = MIN_PERIOD_MS * 1000 * CLK_MHZ;
  localparam int CNT_W = 24;
  // =====================================================
  // current coding, 0.1 A per lsb
  localparam int AMP_W = 10;
  localparam logic [AMP_W-1:0] AMP_MAX_MONITOR = 10'h226;
  localparam logic [AMP_W-1:0] AMP_MAX_SETTING = 10'h1f4;
  localparam logic [AMP_W-1:0] AMP_ZERO = 10'h000;
  localparam logic [15:0] OVER_RANGE_CODE = 16'hffff;
  localparam logic [AMP_W-1:0] BREAK_DEFAULT = 10'h000;
  localparam logic [AMP_W-1:0] OVERCUR_DEFAULT = 10'h1f4;
  localparam logic [AMP_W-1:0] SHORT_DEFAULT = 10'h1f4;
  // =====================================================
  // register byte offsets
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_BREAK1 = 8'h04;
  localparam logic [7:0] REG_OVERCUR1 = 8'h08;
  localparam logic [7:0] REG_SHORT1 = 8'h0c;
  localparam logic [7:0] REG_BREAK2 = 8'h10;
  localparam logic [7:0] REG_OVERCUR2 = 8'h14;
  localparam logic [7:0] REG_SHORT2 = 8'h18;
  localparam logic [7:0] REG_MON_HEAT1 = 8'h1c;
  localparam logic [7:0] REG_MON_LEAK1 = 8'h20;
  localparam logic [7:0] REG_MON_HEAT2 = 8'h24;
  localparam logic [7:0] REG_MON_LEAK2 = 8'h28;
  localparam logic [7:0] REG_STATUS = 8'h2c;
  localparam logic [7:0] REG_MASK = 8'h30;
  localparam logic [7:0] REG_ALARM = 8'h34;
  // control bits
  localparam int CTRL_BREAK_USE = 0;
  localparam int CTRL_OVERCUR_USE = 1;
  localparam int CTRL_SHORT_USE = 2;
  localparam int CTRL_ALARM1_ASSIGNED = 3;
  localparam logic [3:0] CTRL_RESET = 4'h8;
  // alarm bit layout: per channel break, overcurrent, short
  localparam int ALM_W = 6;
  localparam int ALM_BREAK1 = 0;
  localparam int ALM_OVERCUR1 = 1;
  localparam int ALM_SHORT1 = 2;
  localparam int ALM_BREAK2 = 3;
  localparam int ALM_OVERCUR2 = 4;
  localparam int ALM_SHORT2 = 5;

  typedef enum logic [1:0] {
    PH_IDLE = 2'b00,
    PH_ON = 2'b01,
    PH_OFF = 2'b10
  } phase_t;
endpackage : heater_alarm_pkg

// ### channel_if.sv
/*
  per-channel bundle between the top and its channel evaluators.
  assumes one clock for all parties.
*/
`timescale 1ns/100ps
interface channel_if;
  import heater_alarm_pkg::*;
  logic [AMP_W-1:0] sample;
  logic on_done;
  logic off_done;
  logic [AMP_W-1:0] break_th;
  logic [AMP_W-1:0] overcur_th;
  logic [AMP_W-1:0] short_th;
  logic break_use;
  logic overcur_use;
  logic short_use;
  logic [2:0] alarm;
  logic [15:0] mon_heat;
  logic [15:0] mon_leak;
  modport top (output sample, on_done, off_done, break_th, overcur_th, short_th,
               output break_use, overcur_use, short_use,
               input alarm, mon_heat, mon_leak);
  modport chan (input sample, on_done, off_done, break_th, overcur_th, short_th,
                input break_use, overcur_use, short_use,
                output alarm, mon_heat, mon_leak);
endinterface : channel_if

// ### period_timer.sv
/*
  measures each on and off period of the heating output and flags those
  longer than the minimum qualifying time at their end.
  assumes heat_on_in is synchronous to clk_in.
*/
`timescale 1ns/100ps
module period_timer (
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // heating output state
  input wire logic heat_on_in,
  // qualified period ends
  output logic on_done_out,
  output logic off_done_out
);
  import heater_alarm_pkg::*;

  typedef struct packed {
    phase_t phase;
    logic [CNT_W-1:0] count;
    logic on_done;
    logic off_done;
  } timer_state_t;

  timer_state_t state;
  timer_state_t next_state;
  logic long_enough;

  // =====================================================
  // period counting
  always_comb begin
    next_state = state;
    next_state.on_done = 1'b0;
    next_state.off_done = 1'b0;
    long_enough = state.count > CNT_W'(MIN_PERIOD_CYCLES);
    if ((state.phase == PH_ON) != heat_on_in || state.phase == PH_IDLE) begin
      // RL3 short on skipped
      if (state.phase == PH_ON) begin
        next_state.on_done = long_enough;
      end
      // RL4 short off skipped
      if (state.phase == PH_OFF) begin
        next_state.off_done = long_enough;
      end
      next_state.phase = heat_on_in ? PH_ON : PH_OFF;
      next_state.count = CNT_W'(1);
    end else if (!(&state.count)) begin
      next_state.count = state.count + CNT_W'(1);
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign on_done_out = state.on_done;
  assign off_done_out = state.off_done;
endmodule : period_timer

// ### channel_eval.sv
/*
  one current-sense channel: latches the on and off samples, builds
  the monitor values and evaluates break, overcurrent and short alarms.
  assumes samples are tenths of an ampere and done strobes are one cycle.
*/
`timescale 1ns/100ps
module channel_eval (
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // channel bundle
  channel_if.chan ch
);
  import heater_alarm_pkg::*;

  typedef struct packed {
    logic [AMP_W-1:0] heat;
    logic [AMP_W-1:0] leak;
    logic [2:0] alarm;
  } chan_state_t;

  chan_state_t state;
  chan_state_t next_state;

  // RL2 over-range code
  function automatic logic [15:0] monitor(input logic [AMP_W-1:0] amps);
    monitor = (amps > AMP_MAX_MONITOR) ? OVER_RANGE_CODE : {6'h00, amps};
  endfunction : monitor

  // =====================================================
  // evaluation after qualified periods
  always_comb begin
    next_state = state;
    // RL17 evaluate per period
    if (ch.on_done) begin
      next_state.heat = ch.sample;
      // RL5 RL6 break below threshold
      next_state.alarm[0] = ch.break_use && ch.break_th != AMP_ZERO &&
        (ch.sample < ch.break_th || ch.break_th >= AMP_MAX_SETTING);
      // RL7 RL8 overcurrent above threshold
      next_state.alarm[1] = ch.overcur_use && ch.overcur_th < AMP_MAX_SETTING &&
        (ch.sample > ch.overcur_th || ch.overcur_th == AMP_ZERO);
    end
    // RL9 leakage sampled off
    if (ch.off_done) begin
      next_state.leak = ch.sample;
      // RL10 RL11 short above threshold
      next_state.alarm[2] = ch.short_use && ch.short_th < AMP_MAX_SETTING &&
        (ch.sample > ch.short_th || ch.short_th == AMP_ZERO);
    end
    if (!ch.break_use) begin
      next_state.alarm[0] = 1'b0;
    end
    if (!ch.overcur_use) begin
      next_state.alarm[1] = 1'b0;
    end
    // RL16 short needs enable
    if (!ch.short_use) begin
      next_state.alarm[2] = 1'b0;
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  // RL1 monitor values
  assign ch.mon_heat = monitor(state.heat);
  assign ch.mon_leak = monitor(state.leak);
  assign ch.alarm = state.alarm;
endmodule : channel_eval

// ### heater_alarm_checker.sv
/*
  concurrent checks on the top ports of the heater current alarm monitor.
  assumes one clock, clk_in, and a synchronous active-high rst_in.
*/
`timescale 1ns/100ps
module heater_alarm_checker (
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // apb
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic [31:0] prdata_out,
  input wire logic pready_out,
  input wire logic pslverr_out,
  // alarm indications
  input wire logic alarm1_out,
  input wire logic heater_alarm_lamp_out,
  input wire logic [3:0] flash_out,
  input wire logic irq_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);
  // ==========================================
  // apb handshake
  a_ready_one_wait: assert property (psel_in && penable_in && !pready_out |=> pready_out)
    else $error("pready missing one cycle after access");
  a_setup_no_ready: assert property (psel_in && !penable_in |=> !pready_out)
    else $error("pready during setup");
  a_ready_pulse: assert property (pready_out |=> !pready_out)
    else $error("pready longer than one cycle");
  a_ready_cause: assert property (pready_out |-> $past(psel_in && penable_in))
    else $error("pready without access");
  a_err_with_ready: assert property (pslverr_out |-> pready_out)
    else $error("pslverr without pready");
  a_rdata_idle: assert property (!pready_out |-> prdata_out == 32'h0)
    else $error("read data outside ready cycle");
  // ==========================================
  // alarm indications
  a_reset_quiet: assert property ($fell(rst_in) |-> !irq_out && !alarm1_out && flash_out == 4'h0)
    else $error("outputs active after reset");
  a_lamp_flash: assert property (heater_alarm_lamp_out == (|flash_out))
    else $error("lamp and flash disagree");
  a_alarm1_lamp: assert property (alarm1_out |-> heater_alarm_lamp_out)
    else $error("alarm 1 without lamp");
  c_err: cover property (pready_out && pslverr_out);
  c_irq: cover property (irq_out);
  c_short_alarm: cover property (alarm1_out && flash_out[1]);
endmodule : heater_alarm_checker

bind heater_current_alarm_monitor heater_alarm_checker mon_chk (.clk_in(clk_in),
  .rst_in(rst_in), .psel_in(psel_in), .penable_in(penable_in), .prdata_out(prdata_out),
  .pready_out(pready_out), .pslverr_out(pslverr_out), .alarm1_out(alarm1_out),
  .heater_alarm_lamp_out(heater_alarm_lamp_out), .flash_out(flash_out), .irq_out(irq_out));

// ### sense_xfmr_model.sv
/*
  current-sense transformer model: heater current while the output is on,
  leakage through the switch while it is off.
  assumes amplitudes in tenths of an ampere, set by the bench.
*/
`timescale 1ns/100ps
module sense_xfmr_model (
  // heating output
  input wire logic heat_on_in,
  // amplitudes
  input wire logic [heater_alarm_pkg::AMP_W-1:0] on_amp_in,
  input wire logic [heater_alarm_pkg::AMP_W-1:0] leak_amp_in,
  // sensed current
  output logic [heater_alarm_pkg::AMP_W-1:0] sense_out
);
  assign sense_out = heat_on_in ? on_amp_in : leak_amp_in;
endmodule : sense_xfmr_model

// ### tb.sv
/*
  self-checking bench: apb register traffic, forcing threshold writes, short periods.
  assumes the package timing, so no period here is long enough to qualify.
*/
`timescale 1ns/100ps
module tb;
  import heater_alarm_pkg::*;
  logic clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic psel_in = 1'b0;
  logic penable_in = 1'b0;
  logic pwrite_in = 1'b0;
  logic [7:0] paddr_in = 8'h00;
  logic [31:0] pwdata_in = 32'h0;
  logic heat_on_in = 1'b0;
  logic [31:0] prdata_out;
  logic pready_out, pslverr_out, alarm1_out, heater_alarm_lamp_out, irq_out;
  logic [3:0] flash_out;
  logic [AMP_W-1:0] cur1, cur2;
  logic [31:0] rd;
  logic er;
  logic [7:0] lfsr = 8'h2c;
  int n_mismatch = 0;
  int checks_done = 0;
  int rg [14] = '{8, 0, 500, 500, 0, 500, 500, 0, 0, 0, 0, 0, 0, 0};
  logic [7:0] bad [3] = '{8'h38, 8'h3c, 8'hfc};

  always #5 clk_in = ~clk_in;

  heater_current_alarm_monitor heater_current_alarm_monitor_inst (.clk_in(clk_in),
    .rst_in(rst_in), .psel_in(psel_in), .penable_in(penable_in), .pwrite_in(pwrite_in),
    .paddr_in(paddr_in), .pwdata_in(pwdata_in), .prdata_out(prdata_out),
    .pready_out(pready_out), .pslverr_out(pslverr_out), .heat_on_in(heat_on_in),
    .current_sense_input1_in(cur1), .current_sense_input2_in(cur2),
    .alarm1_out(alarm1_out), .heater_alarm_lamp_out(heater_alarm_lamp_out),
    .flash_out(flash_out), .irq_out(irq_out));
  sense_xfmr_model sense1_inst (.heat_on_in(heat_on_in), .on_amp_in(10'h190),
    .leak_amp_in(10'h12c), .sense_out(cur1));
  sense_xfmr_model sense2_inst (.heat_on_in(heat_on_in), .on_amp_in(10'h258),
    .leak_amp_in(10'h064), .sense_out(cur2));

  // ==========================================
  // checking and bus tasks
  function automatic logic [7:0] lfsr_next(input logic [7:0] s);
    lfsr_next = {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction : lfsr_next

  task automatic results();
    if (n_mismatch == 0 && checks_done > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : results

  task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask : cmp

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk_in);
    psel_in <= 1'b1;
    pwrite_in <= wr;
    paddr_in <= a;
    pwdata_in <= d;
    @(posedge clk_in);
    penable_in <= 1'b1;
    @(posedge clk_in);
    for (n = 0; n < 20 && pready_out !== 1'b1; n++) @(posedge clk_in);
    rd = prdata_out;
    er = pslverr_out;
    if (n == 20) cmp("pready", 1, 0);
    psel_in <= 1'b0;
    penable_in <= 1'b0;
  endtask : apb

  task automatic rdchk(input logic [7:0] a);
    apb(1'b0, a, 32'h0);
    cmp($sformatf("reg %h", a), rg[a / 4], rd);
    cmp("pslverr", 0, {31'h0, er});
  endtask : rdchk

  // bench model: latched samples stay zero since no period qualifies
  task automatic check_all();
    logic [5:0] b;
    repeat (4) @(posedge clk_in);
    b = rg[13][5:0];
    cmp("flash", {28'h0, b[5], b[4] | b[3], b[2], b[1] | b[0]}, {28'h0, flash_out});
    cmp("lamp", {31'h0, |b}, {31'h0, heater_alarm_lamp_out});
    cmp("alarm1", {31'h0, (|b) & rg[0][3]}, {31'h0, alarm1_out});
    cmp("irq", {31'h0, |(rg[11] & rg[12])}, {31'h0, irq_out});
    rdchk(REG_ALARM);
    rdchk(REG_STATUS);
  endtask : check_all

  task automatic wr(input int a, input int d);
    int i, old, r;
    apb(1'b1, a[7:0], d);
    i = a / 4;
    old = rg[13];
    r = 0;
    if (i == 0) rg[0] = d & 'hf;
    if (i >= 1 && i <= 6) rg[i] = d > 500 ? 500 : d;
    if (i == 11) rg[11] &= ~d;
    if (i == 12) rg[12] = d & 'h3f;
    // alarms change only at qualified period ends (none here); a cleared use drops them
    r = rg[13] & ((rg[0][0] ? 'o11 : 0) | (rg[0][1] ? 'o22 : 0) | (rg[0][2] ? 'o44 : 0));
    rg[13] = r;
    rg[11] |= r & ~old;
    check_all();
  endtask : wr

  // ==========================================
  // scenarios
  initial begin
    repeat (50000) @(posedge clk_in);
    n_mismatch++;
    results();
  end

  initial begin
    repeat (20) @(posedge clk_in);
    rst_in <= 1'b0;
    for (int a = 0; a < 56; a += 4) rdchk(a[7:0]);
    foreach (bad[i]) begin
      apb(i[0], bad[i], 32'hffffffff);
      cmp("unmapped", 1, {31'h0, er});
    end
    for (int k = 0; k < 12; k++) begin
      lfsr = lfsr_next(lfsr);
      wr(4 + 4 * (k % 6), {lfsr, 2'b11});
      rdchk(8'(4 + 4 * (k % 6)));
    end
    wr(REG_OVERCUR1, 501);
    wr(REG_MON_HEAT1, 'h55);
    for (int k = 1; k < 7; k++) wr(4 * k, k % 3 == 1 ? 0 : 500);
    wr(REG_CTRL, 'hf);
    wr(REG_BREAK1, 500);
    wr(REG_SHORT1, 0);
    wr(REG_OVERCUR2, 0);
    wr(REG_BREAK2, 1);
    wr(REG_MASK, 'h3f);
    wr(REG_STATUS, 'h3f);
    wr(REG_CTRL, 'h7);
    wr(REG_CTRL, 'h3);
    wr(REG_CTRL, 'h8);
    wr(REG_OVERCUR1, 0);
    wr(REG_CTRL, 'hf);
    wr(REG_MASK, 'h0);
    for (int k = 1; k < 7; k++) wr(4 * k, k % 3 == 1 ? 0 : 100);
    for (int k = 0; k < 60; k++) begin
      lfsr = lfsr_next(lfsr);
      repeat (int'(lfsr) + 1) @(posedge clk_in);
      heat_on_in <= ~heat_on_in;
    end
    check_all();
    for (int a = 28; a < 44; a += 4) rdchk(a[7:0]);
    results();
  end
endmodule : tb
